/* File: hw/rxwa_match.sv */
/*
 Masked compare of one candidate window against the pattern.
 Assumes window, pattern and mask share one width.
*/
`timescale 1ns/1ps
module rxwa_match #(
    parameter int W = 20
) (
    input  wire logic [W-1:0] win,
    input  wire logic [W-1:0] pat,
    input  wire logic [W-1:0] mask,
    output logic              hit
);
    assign hit = ((win ^ pat) & mask) == '0;
endmodule // rxwa_match

/* File: hw/rxwa_sync_fsm.sv */
/*
 Acquire/loss state machine for synchronous state machine mode.
 Assumes good and err are one-cycle qualifiers on pclk.
*/
`timescale 1ns/1ps
module rxwa_sync_fsm #(
    parameter int CW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          enable,
    input  wire logic          good,
    input  wire logic          err,
    input  wire logic [CW-1:0] acq_n,
    input  wire logic [CW-1:0] los_n,
    output logic               synced
);
    import rxwa_pkg::*;

    rxwa_sy_t      st_q, st_d;
    logic [CW-1:0] g_q, g_d, e_q, e_d;
    wire  [CW:0]   g_nx = {1'b0, g_q} + 1'b1;
    wire  [CW:0]   e_nx = {1'b0, e_q} + 1'b1;
    wire           acq_hit = good && (g_nx >= {1'b0, acq_n});
    wire           los_hit = err && (e_nx >= {1'b0, los_n});

    assign synced = st_q == SY_LOCK;

    always_comb begin
        st_d = st_q;
        g_d  = g_q;
        e_d  = e_q;
        if (!enable) begin
            st_d = SY_LOSS;
            g_d  = '0;
            e_d  = '0;
        end else begin
            case (st_q)
            SY_LOSS: begin
                if (acq_hit) begin
                    st_d = SY_LOCK;
                    g_d  = '0;
                    e_d  = '0;
                end else if (good) begin
                    g_d = g_nx[CW-1:0];
                end
            end
            SY_LOCK: begin
                if (los_hit) begin
                    st_d = SY_LOSS;
                    e_d  = '0;
                end else if (err) begin
                    e_d = e_nx[CW-1:0];
                end else begin
                    e_d = '0;
                end
            end
            default: st_d = SY_LOSS;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= SY_LOSS;
            g_q  <= '0;
            e_q  <= '0;
        end else begin
            st_q <= st_d;
            g_q  <= g_d;
            e_q  <= e_d;
        end
    end

    a_acq_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable && !synced && good && acq_n != '0
        && g_q == CW'(acq_n - 1'b1) |=> synced)
        else $error("sync not acquired at programmed count");
    a_los_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable && synced && err && los_n != '0
        && e_q == CW'(los_n - 1'b1) |=> !synced)
        else $error("sync not lost at programmed error count");
    a_hold_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable && synced && !err |=> synced)
        else $error("sync dropped without error");
    a_stay_lost: assert property (
        @(posedge pclk) disable iff (!presetn)
        enable && !synced && !good |=> !synced)
        else $error("sync rose without a valid group");
endmodule // rxwa_sync_fsm

/* File: hw/rxwa_top.sv */
/*
 Receive word boundary aligner with APB registers and interrupt.
 Assumes deserializer data, fabric request and bus all on pclk.
*/
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module rxwa_top (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [rxwa_pkg::AW-1:0] paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [rxwa_pkg::DW-1:0] pma_data,
    input  wire logic                    align_request,
    input  wire logic                    bitslip_request,
    input  wire logic                    code_err,
    output rxwa_pkg::rxwa_rx_t           rx,
    output rxwa_pkg::rxwa_slip_t         pma_slip,
    output logic                         irq
);
    import rxwa_pkg::*;

    localparam int SETTLE = DL_SETTLE_CYC;

    rxwa_cfg_t      ctrl_q;
    rxwa_sync_t     sync_q;
    rxwa_rx_t       rx_q;
    rxwa_slip_t     slip_q, slip_d;
    rxwa_dl_t       dl_q, dl_d;
    logic [DW-1:0]  din_q, prev_q, pat_q;
    logic [NST-1:0] st_q, mask_q;
    logic [4:0]     bnd_q, first_off;
    logic [7:0]     cnt_q, cnt_d;
    logic           req_q, bs_q, arm_q, first_q, aligned_q;
    logic           pready_q, pslverr_q, irq_q;
    logic [31:0]    prdata_q;
    logic [DW-1:0]  mraw, hit_vec;
    logic           synced;

    // word width, pattern mask and the two-word search window
    wire [4:0] w_act = ctrl_q.width == W8  ? WV8  :
                       ctrl_q.width == W10 ? WV10 :
                       ctrl_q.width == W16 ? WV16 : WV20;
    wire [DW-1:0] wmask = ~({DW{1'b1}} << w_act);
    wire [DW-1:0] pmask = ~({DW{1'b1}} << ctrl_q.plen);
    wire [2*DW-1:0] cat = ({{DW{1'b0}}, din_q & wmask} << w_act)
                        | {{DW{1'b0}}, prev_q & wmask};

    genvar k;
    generate
        for (k = 0; k < DW; k++) begin : g_off
            rxwa_match #(.W(DW)) u_match (
                .win  (cat[k +: DW]),
                .pat  (pat_q),
                .mask (pmask),
                .hit  (mraw[k])
            );
            assign hit_vec[k] = mraw[k] & (5'(k) < w_act);
        end
    endgenerate

    // lowest matching offset wins so a repeated pattern is stable
    always_comb begin
        first_off = '0;
        for (int i = DW - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                first_off = 5'(i);
            end
        end
    end

    wire any    = |hit_vec;
    wire at_bnd = hit_vec[bnd_q];
    wire bsm    = ctrl_q.mode == MODE_BITSLIP;
    wire man    = ctrl_q.mode == MODE_MANUAL;
    wire sm     = ctrl_q.mode == MODE_SYNCSM;
    wire dl     = ctrl_q.mode == MODE_DETLAT;
    wire level  = ctrl_q.width == W10;

    wire req_rise = align_request & ~req_q;
    wire bs_rise  = bitslip_request & ~bs_q;
    wire armed    = level ? align_request : arm_q;

    wire man_realign = man & armed & any
                     & (first_q | (first_off != bnd_q));
    wire man_hit = man & aligned_q & at_bnd & ~man_realign;
    wire sm_realign = sm & ~synced & any & (~aligned_q | ~at_bnd);
    wire dl_lock  = dl_q == DL_LOCK;
    wire dl_enter = (dl_q == DL_SLIP) & (dl_d == DL_LOCK);
    wire dl_sync  = dl & dl_lock & at_bnd & first_q;

    wire [4:0] bnd_wrap = (bnd_q == w_act - 5'h01) ? 5'h00
                                                   : bnd_q + 5'h01;
    wire [4:0] bnd_d =
        (bsm & bs_rise)              ? bnd_wrap  :
        (man_realign | sm_realign)   ? first_off :
        dl_enter                     ? 5'h00     : bnd_q;

    // sync is a pulse except in sync machine mode; bitslip keeps both low
    wire sync_d = man ? man_realign :
                  sm  ? synced      :
                  dl  ? dl_sync     : 1'b0;
    wire hit_d = (man & (man_realign | man_hit))
               | (sm & aligned_q & at_bnd)
               | (dl & dl_lock & at_bnd);

    rxwa_sync_fsm #(.CW(CW)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (sm),
        .good    (sm & aligned_q & at_bnd),
        .err     (code_err),
        .acq_n   (sync_q.acq),
        .los_n   (sync_q.los),
        .synced  (synced)
    );

    // deterministic latency: find offset, have deserializer slip, settle
    always_comb begin
        dl_d   = dl_q;
        cnt_d  = cnt_q;
        slip_d = '{stb: 1'b0, bits: slip_q.bits};
        if (!dl) begin
            dl_d = DL_IDLE;
        end else if (req_rise) begin
            dl_d = DL_HUNT;
        end else begin
            case (dl_q)
            DL_HUNT: begin
                if (any) begin
                    slip_d = '{stb: 1'b1, bits: first_off};
                    cnt_d  = '0;
                    dl_d   = DL_SLIP;
                end
            end
            DL_SLIP: begin
                if (cnt_q == 8'(SETTLE - 1)) begin
                    dl_d = DL_LOCK;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
            DL_IDLE, DL_LOCK: dl_d = dl_q;
            default: dl_d = DL_IDLE;
            endcase
        end
    end

    function automatic logic cfg_ok(input rxwa_cfg_t c);
        logic p7, p8, p10, p16, p20, pr, ln;
        p7  = c.plen == PL7;
        p8  = c.plen == PL8;
        p10 = c.plen == PL10;
        p16 = c.plen == PL16;
        p20 = c.plen == PL20;
        case (c.mode)
        MODE_BITSLIP: ln = c.width == W8  ? p8  :
                           c.width == W16 ? p16 : p7;
        MODE_MANUAL:  ln = (c.width == W8 || c.width == W16) ? p8 | p16 :
                           p7 | p10 | (p20 & (c.width == W20));
        MODE_SYNCSM:  ln = (c.width == W10 && (p7 | p10))
                         | (c.width == W20 && (p7 | p10 | p20));
        default:      ln = p10 && c.proto == P_CPRI
                         && (c.width == W10 || c.width == W20);
        endcase
        case (c.width)
        W10:     pr = c.proto <= P_GIGE;
        W20:     pr = c.proto <= P_CPRI;
        default: pr = c.proto == P_BASIC;
        endcase
        return pr & ln;
    endfunction

    // APB: no wait state, data and error latched at the setup edge
    wire setup     = psel & ~penable & ~pready_q;
    wire acc       = psel & penable & pready_q;
    wire wr        = acc & pwrite;
    wire sel_ctrl  = paddr == ADDR_CTRL;
    wire sel_pat   = paddr == ADDR_PAT;
    wire sel_sync  = paddr == ADDR_SYNC;
    wire sel_st    = paddr == ADDR_STAT;
    wire sel_mask  = paddr == ADDR_MASK;
    wire sel_state = paddr == ADDR_STATE;
    wire mapped    = sel_ctrl | sel_pat | sel_sync | sel_st | sel_mask
                   | sel_state;
    wire rxwa_cfg_t wcfg = rxwa_cfg_t'(pwdata[$bits(rxwa_cfg_t)-1:0]);
    wire cfg_bad = wr & sel_ctrl & ~cfg_ok(wcfg);
    wire rxwa_state_t state = '{rsv0: '0, arm: arm_q, dl: dl_q,
                                rsv1: '0, aligned: aligned_q,
                                synced: synced, rsv2: '0, bnd: bnd_q};
    wire [31:0] rdata = sel_ctrl  ? 32'(ctrl_q) :
                        sel_pat   ? 32'(pat_q)  :
                        sel_sync  ? 32'(sync_q) :
                        sel_st    ? 32'(st_q)   :
                        sel_mask  ? 32'(mask_q) :
                        sel_state ? 32'(state)  : 32'h0000_0000;

    // set beats clear: an event in the clearing cycle survives
    logic [NST-1:0] ev;
    assign ev[ST_ALIGN]  = man_realign | dl_sync
                         | (sm & synced & ~rx_q.sync);
    assign ev[ST_LOSS]   = sm & ~synced & rx_q.sync;
    assign ev[ST_CFGERR] = cfg_bad;
    assign ev[ST_SLIP]   = slip_d.stb;
    wire [NST-1:0] w1c  = (wr & sel_st) ? pwdata[NST-1:0] : '0;
    wire [NST-1:0] st_d = (st_q & ~w1c) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= setup ? rdata : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            pat_q  <= PAT_RST;
            sync_q <= '{rsv: '0, los: LOS_RST, acq: ACQ_RST};
            mask_q <= MASK_RST;
        end else if (wr) begin
            if (sel_ctrl && !cfg_bad) ctrl_q <= wcfg;
            if (sel_pat) pat_q <= pwdata[DW-1:0];
            if (sel_sync) sync_q <= '{rsv: '0,
                                      los: pwdata[2*CW-1:CW],
                                      acq: pwdata[CW-1:0]};
            if (sel_mask) mask_q <= pwdata[NST-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= '0;
            irq_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            irq_q <= |(st_d & mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_q  <= '0;
            prev_q <= '0;
            req_q  <= 1'b0;
            bs_q   <= 1'b0;
            bnd_q  <= '0;
            dl_q   <= DL_IDLE;
            cnt_q  <= '0;
            slip_q <= '0;
            rx_q   <= '0;
        end else begin
            din_q  <= pma_data;
            prev_q <= din_q;
            req_q  <= align_request;
            bs_q   <= bitslip_request;
            bnd_q  <= bnd_d;
            dl_q   <= dl_d;
            cnt_q  <= cnt_d;
            slip_q <= slip_d;
            // cut at the next boundary so a status pulse rides its own word
            rx_q   <= '{data: cat[bnd_d +: DW] & wmask,
                        sync: sync_d, hit: hit_d};
        end
    end

    // flags: arm for edge mode, first-pattern tracking, aligned at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q     <= 1'b0;
            first_q   <= 1'b1;
            aligned_q <= 1'b0;
        end else begin
            // a rise seen in another mode must not arm a later manual mode
            arm_q     <= man & (req_rise | (arm_q & ~man_realign));
            first_q   <= req_rise | (first_q & ~man_realign & ~dl_sync);
            aligned_q <= ~bsm & (aligned_q | man_realign | sm_realign
                                 | dl_enter);
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign rx       = rx_q;
    assign pma_slip = slip_q;
    assign irq      = irq_q;

    a_edge_req: assert property (
        @(posedge pclk) disable iff (!presetn)
        man && !level && req_q && align_request && !arm_q
        |=> bnd_q == $past(bnd_q))
        else $error("held request moved boundary in edge mode");
    a_realign: assert property (
        @(posedge pclk) disable iff (!presetn)
        man && armed && any && (first_q || first_off != bnd_q)
        |=> bnd_q == $past(first_off) && rx_q.sync)
        else $error("requested realign missing or unsignalled");
    a_hold_bnd: assert property (
        @(posedge pclk) disable iff (!presetn)
        man && !armed |=> bnd_q == $past(bnd_q))
        else $error("boundary moved without request");
    a_same_lat: assert property (
        @(posedge pclk) disable iff (!presetn)
        man && rx_q.sync |-> rx_q.hit)
        else $error("sync pulse without its hit");
    a_sync_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        man && !level && rx_q.sync |=> !rx_q.sync)
        else $error("manual sync longer than one cycle");
    a_hit_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        man && aligned_q && !armed && at_bnd
        |=> rx_q.hit && !rx_q.sync)
        else $error("same-boundary pattern not a hit-only pulse");
    a_dl_hunt: assert property (
        @(posedge pclk) disable iff (!presetn)
        dl && req_rise |=> dl_q == DL_HUNT)
        else $error("latency request did not restart search");
    a_dl_settle: assert property (
        @(posedge pclk) disable iff (!presetn)
        (slip_q.stb && dl) ##1 (dl && !req_rise)[*8]
        ##1 (dl && !req_rise) |=> dl_q == DL_LOCK)
        else $error("no alignment after slip settle time");
    a_cfg_reject: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg_bad |=> ctrl_q == $past(ctrl_q) && st_q[ST_CFGERR])
        else $error("illegal configuration accepted");
    a_slip_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        bsm && $past(bsm) |-> !rx_q.sync && !rx_q.hit)
        else $error("status shown in bit slip mode");
    a_reset_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        man && !aligned_q && !man_realign |=> !rx_q.hit && !rx_q.sync)
        else $error("status before first alignment");
endmodule // rxwa_top

/* File: pkg/rxwa_pkg.sv */
/*
 Shared constants and types of the receive word aligner.
 Assumes one 50 MHz parallel clock for bus, data and fabric.
*/
package rxwa_pkg;
    localparam int DW = 20;
    localparam int AW = 8;
    localparam int CW = 8;
    localparam int CLK_NS = 20;
    localparam int DL_SETTLE_NS = 200;
    localparam int DL_SETTLE_CYC = (DL_SETTLE_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [AW-1:0] ADDR_CTRL  = 8'h00;
    localparam logic [AW-1:0] ADDR_PAT   = 8'h04;
    localparam logic [AW-1:0] ADDR_SYNC  = 8'h08;
    localparam logic [AW-1:0] ADDR_STAT  = 8'h0C;
    localparam logic [AW-1:0] ADDR_MASK  = 8'h10;
    localparam logic [AW-1:0] ADDR_STATE = 8'h14;

    localparam logic [1:0] MODE_BITSLIP = 2'h0;
    localparam logic [1:0] MODE_MANUAL  = 2'h1;
    localparam logic [1:0] MODE_SYNCSM  = 2'h2;
    localparam logic [1:0] MODE_DETLAT  = 2'h3;
    localparam logic [1:0] W8  = 2'h0;
    localparam logic [1:0] W10 = 2'h1;
    localparam logic [1:0] W16 = 2'h2;
    localparam logic [1:0] W20 = 2'h3;
    localparam logic [4:0] WV8  = 5'h08;
    localparam logic [4:0] WV10 = 5'h0A;
    localparam logic [4:0] WV16 = 5'h10;
    localparam logic [4:0] WV20 = 5'h14;
    localparam logic [4:0] PL7  = 5'h07;
    localparam logic [4:0] PL8  = 5'h08;
    localparam logic [4:0] PL10 = 5'h0A;
    localparam logic [4:0] PL16 = 5'h10;
    localparam logic [4:0] PL20 = 5'h14;
    localparam logic [2:0] P_BASIC    = 3'h0;
    localparam logic [2:0] P_BASIC_RM = 3'h1;
    localparam logic [2:0] P_CPRI     = 3'h2;
    localparam logic [2:0] P_PCIE     = 3'h3;
    localparam logic [2:0] P_GIGE     = 3'h4;

    localparam int NST       = 4;
    localparam int ST_ALIGN  = 0;
    localparam int ST_LOSS   = 1;
    localparam int ST_CFGERR = 2;
    localparam int ST_SLIP   = 3;

    typedef enum logic [3:0] {
        DL_IDLE = 4'h1, DL_HUNT = 4'h2, DL_SLIP = 4'h4, DL_LOCK = 4'h8
    } rxwa_dl_t;
    typedef enum logic [1:0] {SY_LOSS = 2'h1, SY_LOCK = 2'h2} rxwa_sy_t;

    typedef struct packed {
        logic [2:0] proto;
        logic [4:0] plen;
        logic [1:0] width;
        logic [1:0] mode;
    } rxwa_cfg_t;
    typedef struct packed {
        logic [15:0]   rsv;
        logic [CW-1:0] los;
        logic [CW-1:0] acq;
    } rxwa_sync_t;
    typedef struct packed {
        logic [14:0] rsv0;
        logic        arm;
        rxwa_dl_t    dl;
        logic [1:0]  rsv1;
        logic        aligned;
        logic        synced;
        logic [2:0]  rsv2;
        logic [4:0]  bnd;
    } rxwa_state_t;
    typedef struct packed {
        logic [DW-1:0] data;
        logic          sync;
        logic          hit;
    } rxwa_rx_t;
    typedef struct packed {
        logic       stb;
        logic [4:0] bits;
    } rxwa_slip_t;

    localparam rxwa_cfg_t CTRL_RST = '{proto: P_BASIC, plen: PL10,
                                      width: W10, mode: MODE_MANUAL};
    localparam logic [DW-1:0] PAT_RST  = 20'h0017C;
    localparam logic [CW-1:0] ACQ_RST  = 8'h04;
    localparam logic [CW-1:0] LOS_RST  = 8'h04;
    localparam logic [NST-1:0] MASK_RST = 4'h0;
endpackage

/* File: tb/rxwa_pma.sv */
/*
 Deserializer model: 10-bit words cut from a 20-bit repeating stream.
 Assumes pclk is the parallel clock; slip strobes drop serial bits.
*/
`timescale 1ns/1ps
module rxwa_pma (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 kick,
    input  wire rxwa_pkg::rxwa_slip_t slip,
    output logic [rxwa_pkg::DW-1:0]   pma_data
);
    import rxwa_pkg::*;
    // pattern then ten zeros, so only one offset can match
    localparam logic [19:0] STRM = 20'h0017C;
    logic [4:0] pos_q;
    logic [4:0] ph_q;
    logic [9:0] w;
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            w[i] = STRM[(pos_q + ph_q + i) % 20];
        end
    end
    // upper half is junk that the aligner has to ignore at width 10
    assign pma_data = {~w, w};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 5'h00;
            ph_q  <= 5'h00;
        end else begin
            pos_q <= (pos_q == 5'h00) ? 5'h0A : 5'h00;
            ph_q  <= 5'((ph_q + kick + (slip.stb ? slip.bits : 5'h00))
                     % 20);
        end
    end
endmodule // rxwa_pma

/* File: tb/tb.sv */
/*
 Self-checking bench: APB calls and fabric pins around the aligner.
 Assumes rxwa_pma stands in for the deserializer.
*/
`timescale 1ns/1ps
module tb;
    import rxwa_pkg::*;
    logic          pclk = 1'b0, presetn = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]   pwdata = 32'h0, prdata, rd;
    logic          pready, pslverr, irq, er, shit;
    logic          align_request = 1'b0, bitslip_request = 1'b0;
    logic          code_err = 1'b0, kick = 1'b0;
    logic [DW-1:0] pma_data, sdat;
    rxwa_rx_t      rx;
    rxwa_slip_t    pma_slip;
    int            errors = 0, checked = 0, n_sync = 0, n_hit = 0, s0, h0;
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        if (rx.sync === 1'b1) begin
            n_sync <= n_sync + 1;
            sdat <= rx.data;
            shit <= rx.hit;
        end
        if (rx.hit === 1'b1) n_hit <= n_hit + 1;
    end
    rxwa_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pma_data(pma_data), .align_request(align_request),
        .bitslip_request(bitslip_request), .code_err(code_err),
        .rx(rx), .pma_slip(pma_slip), .irq(irq));
    rxwa_pma i_pma (.pclk(pclk), .presetn(presetn), .kick(kick),
        .slip(pma_slip), .pma_data(pma_data));
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // shifts the serial stream by one bit behind the aligner's back
    task automatic bump();
        kick <= 1'b1;
        cyc(1);
        kick <= 1'b0;
        cyc(8);
    endtask
    task automatic await_sync();
        int n;
        s0 = n_sync;
        for (n = 0; n < 300 && n_sync == s0; n++) @(posedge pclk);
        cyc(1);
        chk(32'(n_sync != s0), 1);
    endtask
    task automatic give_verdict();
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    initial begin
        cyc(16);
        presetn <= 1'b1;
        rchk(ADDR_CTRL, 32'(CTRL_RST));
        rchk(ADDR_PAT, 32'(PAT_RST));
        rchk(ADDR_SYNC, {16'h0, LOS_RST, ACQ_RST});
        rchk(ADDR_MASK, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(er), 1);
        chk(n_sync + n_hit, 0);
        bump();
        apb(1'b1, ADDR_MASK, 32'h1);
        align_request <= 1'b1;
        await_sync();
        chk(sdat, 32'h17C);
        chk(32'(shit), 1);
        align_request <= 1'b0;
        cyc(4);
        chk(32'(irq), 1);
        apb(1'b1, ADDR_STAT, 32'h1);
        cyc(1);
        chk(32'(irq), 0);
        apb(1'b1, ADDR_MASK, 32'h0);
        s0 = n_sync;
        h0 = n_hit;
        cyc(40);
        chk(n_sync - s0, 0);
        chk(32'(n_hit > h0), 1);
        bump();
        s0 = n_sync;
        h0 = n_hit;
        cyc(40);
        chk(n_sync - s0, 0);
        chk(n_hit - h0, 0);
        align_request <= 1'b1;
        await_sync();
        chk(sdat, 32'h17C);
        s0 = n_sync;
        bump();
        cyc(4);
        chk(32'(n_sync != s0), 1);
        chk(sdat, 32'h17C);
        align_request <= 1'b0;
        chk(32'(irq), 0);
        apb(1'b1, ADDR_CTRL, 32'hA6);
        await_sync();
        code_err <= 1'b1;
        for (s0 = 0; s0 < 50 && rx.sync !== 1'b0; s0++) @(posedge pclk);
        chk(32'(s0 >= 4 && s0 <= 8), 1);
        code_err <= 1'b0;
        cyc(2);
        chk(32'(rx.sync), 0);
        await_sync();
        apb(1'b1, ADDR_CTRL, 32'h4A7);
        bump();
        align_request <= 1'b1;
        await_sync();
        chk(sdat, 32'h17C);
        apb(1'b0, ADDR_STATE, 32'h0);
        chk(32'(rd[4:0]), 0);
        align_request <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h481);
        rchk(ADDR_CTRL, 32'h4A7);
        apb(1'b1, ADDR_CTRL, 32'h85);
        rchk(ADDR_CTRL, 32'h4A7);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(32'(rd[2]), 1);
        apb(1'b1, ADDR_CTRL, 32'h74);
        apb(1'b0, ADDR_STATE, 32'h0);
        h0 = rd[4:0];
        s0 = n_sync;
        bitslip_request <= 1'b1;
        cyc(2);
        bitslip_request <= 1'b0;
        cyc(4);
        apb(1'b0, ADDR_STATE, 32'h0);
        chk(32'(rd[4:0]), (h0 + 1) % 10);
        chk(n_sync - s0, 0);
        // width 8 manual: request is edge sensitive
        apb(1'b1, ADDR_CTRL, 32'h81);
        align_request <= 1'b1;
        await_sync();
        chk(sdat, 32'h7C);
        s0 = n_sync;
        bump();
        cyc(20);
        chk(n_sync - s0, 0);
        align_request <= 1'b0;
        cyc(2);
        align_request <= 1'b1;
        await_sync();
        chk(sdat, 32'h7C);
        align_request <= 1'b0;
        give_verdict();
    end
endmodule // tb
